// file: hdl/iird_pkg.sv
// shared constants and carrier types for the isa interrupt/dma routing glue
package iird_pkg;
    localparam int IRQ_LINES = 16;
    localparam int DMA_CHANS = 8;
    localparam int SYNC_STAGES = 3;
    // isa request numbers
    localparam int IRQ_TIMER = 0;
    localparam int IRQ_CASCADE = 2;
    localparam int IRQ_SECOND_ASYNC = 3;
    localparam int IRQ_FIRST_ASYNC = 4;
    localparam int IRQ_PARALLEL = 7;
    localparam int IRQ_SHARED = 9;
    localparam int IRQ_ETHERNET = 10;
    localparam int IRQ_SCSI = 14;
    localparam int SEC_BASE = 8;
    // dma channel numbers
    localparam int DMA_A_WAIT = 0;
    localparam int DMA_A_TERM = 1;
    localparam int DMA_PAIR_TWO = 2;
    localparam int DMA_PAIR_THREE = 3;
    localparam int DMA_CASCADE = 4;
    localparam int DMA_B_WAIT = 5;
    localparam int DMA_B_TERM = 6;
    localparam int DMA_UNUSED = 7;
    // trigger mode reset value: all edge
    localparam logic [15:0] LEVEL_MODE_RESET = 16'h0000;

    // pin-side interrupt sources, all raw levels as seen on the pins
    typedef struct packed {
        logic ethernet_n;     // active low level
        logic scsi_n;         // active low level
        logic counter_io;     // active high level
        logic serial_comm;    // active high level
        logic first_async;    // active high edge
        logic second_async;   // active high edge
        logic parallel;       // active high edge
    } iird_irq_src_t;

    // pin-side dma requests from serial and super io
    typedef struct packed {
        logic chan_a_wait_request;
        logic chan_a_terminal_request;
        logic chan_b_wait_request;
        logic chan_b_terminal_request;
        logic dma_pair_two;
        logic dma_pair_three;
    } iird_dma_src_t;

    // pseudo acknowledge grants
    typedef struct packed {
        logic counter_io;
        logic serial_comm;
    } iird_ack_t;

    typedef enum {ACK_IDLE, ACK_CIO, ACK_SCC} iird_ack_state_t;
endpackage : iird_pkg

// file: hdl/iird_sync.sv
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none
module iird_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic din,
    output var logic dout
);
    logic s1;
    logic s2;
    logic s3;

    // first stage feeds only the second; change counts once 2 and 3 agree
    always_ff @(posedge clk) begin
        if (reset) begin
            s1 <= RESET_LEVEL;
            s2 <= RESET_LEVEL;
            s3 <= RESET_LEVEL;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // filtered level holds while stages disagree
    always_ff @(posedge clk) begin
        if (reset) begin
            dout <= RESET_LEVEL;
        end else if (ce && (s2 == s3)) begin
            dout <= s3;
        end
    end
endmodule : iird_sync
`default_nettype wire

// file: hdl/iird_routing.sv
// isa interrupt and dma routing glue around the pci_isa_bridge
//
// Behaviour
// - bridge output to host input 0, high level
// - scsi interrupt to host input 9, low
// - ethernet port two to request 10
// - scsi interrupt also feeds request 14
// - timer counter drives request 0, edge
// - secondary cascade output drives request 2
// - pseudo acknowledge prefers counter device over serial
// - all request lines edge mode after reset
// - async ports 3 and 4, parallel 7
// - serial channel requests drive dma 0,1,5,6
// - dma 2 and 3 to super io
// - dma 4 internal cascade, 7 unconnected
// - serial controller drives vector once selected
`timescale 1ns/1ps
`default_nettype none
module iird_routing
    import iird_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire iird_irq_src_t IRQ_SRC,
    input wire iird_dma_src_t DMA_SRC,
    input wire logic TIMER_TICK,
    input wire logic PSEUDO_IACK,
    input wire logic MODE_WE,
    input wire logic [IRQ_LINES-1:0] MODE_WDATA,
    input wire logic [IRQ_LINES-1:0] IRQ_MASK,
    output logic HOST_IRQ0,
    output logic HOST_IRQ9_N,
    output logic [IRQ_LINES-1:0] ISA_IRQ,
    output logic [IRQ_LINES-1:0] LEVEL_MODE,
    output logic [DMA_CHANS-1:0] DMA_REQ,
    output var iird_ack_t IACK_GRANT,
    output logic VECTOR_ENABLE
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int NSRC = $bits(iird_irq_src_t) + $bits(iird_dma_src_t);
    logic [NSRC-1:0] raw;
    logic [NSRC-1:0] syn;
    // low-active pins rest high so reset does not fake a request
    localparam logic [NSRC-1:0] REST = {2'b11, {(NSRC-2){1'b0}}};
    iird_irq_src_t irq_s;
    iird_dma_src_t dma_s;

    // the fixed pin map below serves exactly 16 lines and 8 channels
    if (IRQ_LINES != 16 || DMA_CHANS != 8) begin : g_bad_size
        $error("iird_routing: fixed 16 irq / 8 dma map");
    end

    assign raw = {IRQ_SRC, DMA_SRC};
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_sync
            iird_sync #(.RESET_LEVEL(REST[gi])) u_sync (
                .clk(CLK),
                .reset(RESET),
                .ce(CE),
                .din(raw[gi]),
                .dout(syn[gi])
            );
        end
    endgenerate
    assign irq_s = syn[NSRC-1 -: $bits(iird_irq_src_t)];
    assign dma_s = syn[$bits(iird_dma_src_t)-1:0];

    ////////////////////////////////////////////////////////////////////////
    // trigger mode store, edge everywhere after reset
    logic [IRQ_LINES-1:0] level_mode;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            level_mode <= LEVEL_MODE_RESET;
        end else if (CE && MODE_WE) begin
            level_mode <= MODE_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request line assembly, normalised to active high inside the bridge
    logic [IRQ_LINES-1:0] req_raw;
    logic sec_out;
    always_comb begin
        req_raw = '0;
        req_raw[IRQ_TIMER] = TIMER_TICK;
        req_raw[IRQ_SECOND_ASYNC] = irq_s.second_async;
        req_raw[IRQ_FIRST_ASYNC] = irq_s.first_async;
        req_raw[IRQ_PARALLEL] = irq_s.parallel;
        // shared line: either source holds it high
        req_raw[IRQ_SHARED] = irq_s.counter_io | irq_s.serial_comm;
        req_raw[IRQ_ETHERNET] = ~irq_s.ethernet_n;
        req_raw[IRQ_SCSI] = ~irq_s.scsi_n;
    end

    // edge detect history for edge-mode lines
    logic [IRQ_LINES-1:0] req_prev;
    logic [IRQ_LINES-1:0] pend;
    logic [IRQ_LINES-1:0] next_pend;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            req_prev <= '0;
        end else if (CE) begin
            req_prev <= req_raw;
        end
    end

    // edge lines latch on a rise and drop with the source;
    // level lines follow the source, so they hold until it is cleared
    always_comb begin
        for (int i = 0; i < IRQ_LINES; i++) begin
            if (level_mode[i]) begin
                next_pend[i] = req_raw[i];
            end else begin
                next_pend[i] = (pend[i] | (req_raw[i] & ~req_prev[i]))
                               & req_raw[i];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pend <= '0;
        end else if (CE) begin
            pend <= next_pend;
        end
    end

    // secondary cascade output onto primary line 2
    assign sec_out = |(pend[IRQ_LINES-1:SEC_BASE]
                       & ~IRQ_MASK[IRQ_LINES-1:SEC_BASE]);

    // isa line view plus cascade; registered so outputs are flops
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ISA_IRQ <= '0;
        end else if (CE) begin
            ISA_IRQ <= pend;
            ISA_IRQ[IRQ_CASCADE] <= sec_out;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            LEVEL_MODE <= LEVEL_MODE_RESET;
        end else if (CE) begin
            LEVEL_MODE <= level_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host side outputs
    logic pri_out;
    assign pri_out = |(pend[SEC_BASE-1:0] & ~IRQ_MASK[SEC_BASE-1:0]) | sec_out;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            HOST_IRQ0 <= 1'b0;
            HOST_IRQ9_N <= 1'b1;
        end else if (CE) begin
            HOST_IRQ0 <= pri_out;
            HOST_IRQ9_N <= irq_s.scsi_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dma request wiring; 4 and 7 are never driven from outside
    always_ff @(posedge CLK) begin
        if (RESET) begin
            DMA_REQ <= '0;
        end else if (CE) begin
            DMA_REQ <= '0;
            DMA_REQ[DMA_A_WAIT] <= dma_s.chan_a_wait_request;
            DMA_REQ[DMA_A_TERM] <= dma_s.chan_a_terminal_request;
            DMA_REQ[DMA_B_WAIT] <= dma_s.chan_b_wait_request;
            DMA_REQ[DMA_B_TERM] <= dma_s.chan_b_terminal_request;
            DMA_REQ[DMA_PAIR_TWO] <= dma_s.dma_pair_two;
            DMA_REQ[DMA_PAIR_THREE] <= dma_s.dma_pair_three;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pseudo acknowledge selection; choice frozen for the whole cycle
    iird_ack_state_t ack_state;
    iird_ack_state_t next_ack_state;
    always_comb begin
        next_ack_state = ack_state;
        case (ack_state)
            ACK_IDLE: begin
                if (PSEUDO_IACK && irq_s.counter_io) begin
                    next_ack_state = ACK_CIO;
                end else if (PSEUDO_IACK && irq_s.serial_comm) begin
                    next_ack_state = ACK_SCC;
                end else begin
                    next_ack_state = ACK_IDLE;
                end
            end
            ACK_CIO, ACK_SCC: begin
                if (!PSEUDO_IACK) begin
                    next_ack_state = ACK_IDLE;
                end
            end
            default: next_ack_state = ACK_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ack_state <= ACK_IDLE;
        end else if (CE) begin
            ack_state <= next_ack_state;
        end
    end

    // grants and vector drive come from flops, loaded on the same edge as the state
    always_ff @(posedge CLK) begin
        if (RESET) begin
            IACK_GRANT <= '0;
            VECTOR_ENABLE <= 1'b0;
        end else if (CE) begin
            IACK_GRANT.counter_io <= (next_ack_state == ACK_CIO);
            IACK_GRANT.serial_comm <= (next_ack_state == ACK_SCC);
            VECTOR_ENABLE <= (next_ack_state == ACK_SCC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // output flop shows the synced pin of the enabled edge before
    chk_host_irq9_follow: assert property (
        @(posedge CLK) disable iff (RESET)
        CE |=> HOST_IRQ9_N == $past(irq_s.scsi_n))
        else $error("host irq9 does not follow scsi");
    chk_mode_after_reset: assert property (
        @(posedge CLK)
        $fell(RESET) |-> level_mode == '0)
        else $error("trigger mode not edge after reset");
    chk_cio_priority: assert property (
        @(posedge CLK) disable iff (RESET)
        CE && ack_state == ACK_IDLE && PSEUDO_IACK && irq_s.counter_io
        |=> ack_state == ACK_CIO)
        else $error("counter device not preferred");
    // grants are chosen from the same edge, so look one cycle on only
    chk_no_ack_idle: assert property (
        @(posedge CLK) disable iff (RESET)
        CE && ack_state == ACK_IDLE && !irq_s.counter_io
            && !irq_s.serial_comm
        |=> !IACK_GRANT.counter_io && !IACK_GRANT.serial_comm)
        else $error("acknowledge with nothing pending");
    chk_grant_onehot: assert property (
        @(posedge CLK) disable iff (RESET)
        !(IACK_GRANT.counter_io && IACK_GRANT.serial_comm))
        else $error("both devices acknowledged");
    chk_level_hold: assert property (
        @(posedge CLK) disable iff (RESET)
        CE && level_mode[IRQ_ETHERNET] && req_raw[IRQ_ETHERNET]
        |=> pend[IRQ_ETHERNET])
        else $error("level request dropped early");
    chk_dma_fixed: assert property (
        @(posedge CLK) disable iff (RESET)
        !DMA_REQ[DMA_CASCADE] && !DMA_REQ[DMA_UNUSED])
        else $error("unconnected dma channel driven");
    chk_host_irq0: assert property (
        @(posedge CLK) disable iff (RESET)
        CE && pri_out ##1 CE |-> HOST_IRQ0)
        else $error("host irq0 missing");
    chk_dma_a_wait: assert property (
        @(posedge CLK) disable iff (RESET)
        CE |=> DMA_REQ[DMA_A_WAIT] == $past(dma_s.chan_a_wait_request))
        else $error("dma 0 not routed");
endmodule : iird_routing
`default_nettype wire

// file: sim/iird_host_model.sv
// host interrupt controller model: latches the two level requests
`timescale 1ns/1ps
`default_nettype none
module iird_host_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic in0,
    input wire logic in9_n,
    output var logic [1:0] pending
);
    // level inputs only, so pending simply follows the pins each cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            pending <= 2'h0;
        end else begin
            pending[0] <= in0; // input 0 is high active
            pending[1] <= !in9_n; // input 9 is low active
        end
    end
endmodule : iird_host_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the isa interrupt and dma routing glue
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import iird_pkg::*;
    logic clk, reset, ce, timer_tick, pseudo_iack, mode_we;
    iird_irq_src_t irq_src;
    iird_dma_src_t dma_src;
    logic [15:0] mode_wdata, irq_mask, isa_irq, level_mode, m, e;
    logic host_irq0, host_irq9_n, vector_enable;
    logic [7:0] dma_req;
    logic [1:0] host_pending;
    logic [31:0] r;
    iird_ack_t iack_grant;
    int num_errors = 0;
    int checked = 0;
    int seed = 32'h1a3ea2bc;
    ////////////////////////////////////////////////////////////////////////
    iird_routing i_iird_routing (.CLK(clk), .RESET(reset), .CE(ce),
        .IRQ_SRC(irq_src), .DMA_SRC(dma_src), .TIMER_TICK(timer_tick),
        .PSEUDO_IACK(pseudo_iack), .MODE_WE(mode_we),
        .MODE_WDATA(mode_wdata), .IRQ_MASK(irq_mask),
        .HOST_IRQ0(host_irq0), .HOST_IRQ9_N(host_irq9_n),
        .ISA_IRQ(isa_irq), .LEVEL_MODE(level_mode), .DMA_REQ(dma_req),
        .IACK_GRANT(iack_grant), .VECTOR_ENABLE(vector_enable));
    iird_host_model i_iird_host_model (.clk(clk), .reset(reset),
        .in0(host_irq0), .in9_n(host_irq9_n), .pending(host_pending));
    ////////////////////////////////////////////////////////////////////////
    // expected pending lines; cascade only sees unmasked secondary lines
    function automatic logic [15:0] exp_isa(iird_irq_src_t s, logic t,
            logic [15:0] mk);
        logic [15:0] v;
        v = 16'h0000;
        v[IRQ_TIMER] = t;
        v[IRQ_SECOND_ASYNC] = s.second_async;
        v[IRQ_FIRST_ASYNC] = s.first_async;
        v[IRQ_PARALLEL] = s.parallel;
        v[IRQ_SHARED] = s.counter_io | s.serial_comm;
        v[IRQ_ETHERNET] = !s.ethernet_n;
        v[IRQ_SCSI] = !s.scsi_n;
        v[IRQ_CASCADE] = |(v[15:SEC_BASE] & ~mk[15:SEC_BASE]);
        return v;
    endfunction : exp_isa
    function automatic logic [15:0] exp_dma(iird_dma_src_t d);
        logic [15:0] v;
        v = 16'h0000;
        v[DMA_A_WAIT] = d.chan_a_wait_request;
        v[DMA_A_TERM] = d.chan_a_terminal_request;
        v[DMA_PAIR_TWO] = d.dma_pair_two;
        v[DMA_PAIR_THREE] = d.dma_pair_three;
        v[DMA_B_WAIT] = d.chan_b_wait_request;
        v[DMA_B_TERM] = d.chan_b_terminal_request;
        return v;
    endfunction : exp_dma
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] ex, logic [15:0] got);
        checked++;
        if (got !== ex) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
        end
    endtask : check
    // longer than the five to seven cycle pin-to-output path
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask : settle
    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        settle();
    endtask : do_reset
    task automatic program_mode(logic [15:0] v);
        @(posedge clk);
        mode_we <= 1'b1;
        mode_wdata <= v;
        @(posedge clk);
        mode_we <= 1'b0;
        settle();
    endtask : program_mode
    task automatic test_done();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // the whole run is near 600 cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        timer_tick = 1'b0;
        pseudo_iack = 1'b0;
        mode_we = 1'b0;
        mode_wdata = 16'h0000;
        irq_mask = 16'h0000;
        irq_src = iird_irq_src_t'(7'h60);
        dma_src = iird_dma_src_t'(6'h00);
        do_reset();
        check("mode", 16'h0000, level_mode);
        check("isa", 16'h0000, isa_irq);
        check("host0", 16'h0000, {15'h0, host_irq0});
        check("host9n", 16'h0001, {15'h0, host_irq9_n});
        check("dma", 16'h0000, {8'h0, dma_req});
        // mode survives until any reset, then all lines fall back to edge
        program_mode(16'hffff);
        check("mode", 16'hffff, level_mode);
        do_reset();
        check("mode", 16'h0000, level_mode);
        // shared and ethernet lines level, so the hold check sees traffic
        program_mode(16'h0600);
        check("mode", 16'h0600, level_mode);
        // first two passes are corners: all sources up, unmasked then masked
        for (int i = 0; i < 40; i++) begin
            r = (i < 2) ? 32'h00003f9f : $random(seed);
            m = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
            @(posedge clk);
            irq_src <= iird_irq_src_t'(r[6:0]);
            dma_src <= iird_dma_src_t'(r[12:7]);
            timer_tick <= r[13];
            irq_mask <= m & 16'hfffb;
            settle();
            e = exp_isa(irq_src, timer_tick, irq_mask);
            check("isa", e, isa_irq);
            check("host0", {15'h0, |(e & ~irq_mask)},
                {15'h0, host_irq0});
            check("host9n", {15'h0, irq_src.scsi_n},
                {15'h0, host_irq9_n});
            check("dma", exp_dma(dma_src),
                {8'h0, dma_req});
            check("pend", {14'h0, e[IRQ_SCSI], |(e & ~irq_mask)},
                {14'h0, host_pending});
        end
        // clock enable low freezes the whole path, pins included
        @(posedge clk);
        ce <= 1'b0;
        dma_src <= iird_dma_src_t'(~r[12:7]);
        settle();
        check("dma", exp_dma(iird_dma_src_t'(r[12:7])),
            {8'h0, dma_req});
        @(posedge clk);
        ce <= 1'b1;
        settle();
        check("dma", exp_dma(dma_src), {8'h0, dma_req});
        // every pairing of the two shared requests through a pseudo cycle
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            irq_src <= iird_irq_src_t'({2'b11, k[1], k[0], 3'b000});
            settle();
            e = k[1] ? 16'h0002 : (k[0] ? 16'h0001 : 16'h0000);
            @(posedge clk);
            pseudo_iack <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
            check("grant", e, {14'h0, iack_grant});
            check("vector", {15'h0, e[0]}, {15'h0, vector_enable});
            @(posedge clk);
            pseudo_iack <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            check("grant", 16'h0000, {14'h0, iack_grant});
        end
        test_done();
    end
endmodule : testbench
`default_nettype wire
